/* inc/adc_ctrl_pkg.sv */
// Constants shared by the converter control block
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_CONTROL     = 10'h093;
  localparam logic [9:0] IDX_TIMING      = 10'h094;
  localparam logic [9:0] IDX_PIN_FUNC    = 10'h095;
  localparam logic [9:0] IDX_RESULT_LOW  = 10'h096;
  localparam logic [9:0] IDX_RESULT_HIGH = 10'h097;
  localparam logic [9:0] IDX_IRQ_STATUS  = 10'h098;
  localparam logic [9:0] IDX_IRQ_MASK    = 10'h099;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_ON_BIT      = 7;
  localparam int CTL_DONE_BIT    = 6;
  localparam int CTL_CMP_BIT     = 5;
  localparam int CTL_REF_BIT     = 4;
  localparam int CTL_SEL_LSB     = 1;
  localparam int CTL_GO_BIT      = 0;
  localparam int TIM_DIV_LSB     = 5;
  localparam int TIM_SAMPLE_LSB  = 0;
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_CMP_BIT     = 1;
  localparam int IRQ_WIDTH       = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [9:0] RST_RESULT = 10'h000;
  localparam logic [1:0] RST_IRQ    = 2'h0;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam logic [5:0] DIV_CYC_0 = 6'h02;
  localparam logic [5:0] DIV_CYC_1 = 6'h04;
  localparam logic [5:0] DIV_CYC_2 = 6'h06;
  localparam logic [5:0] DIV_CYC_3 = 6'h08;
  localparam logic [5:0] DIV_CYC_4 = 6'h0C;
  localparam logic [5:0] DIV_CYC_5 = 6'h10;
  localparam logic [5:0] DIV_CYC_6 = 6'h18;
  localparam logic [5:0] DIV_CYC_7 = 6'h20;
  localparam logic [4:0] SAMPLE_MIN  = 5'h02;
  localparam logic [4:0] SAMPLE_MAX  = 5'h0F;
  localparam logic [4:0] CONVERT_LEN = 5'h0C;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } conv_state_e;

endpackage

/* design/conv_clk_divider.sv */
// Conversion clock divider: one tick per conversion clock period
`timescale 1ns/1ns
`default_nettype none
module conv_clk_divider (
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_run,
  input  wire logic [2:0] i_div_code,
  output logic            o_tick,
  output logic            o_clk_level_q
);

  logic [5:0] period;
  logic [5:0] cnt_q;

  always_comb begin
    case (i_div_code)
      3'h0:    period = adc_ctrl_pkg::DIV_CYC_0;
      3'h1:    period = adc_ctrl_pkg::DIV_CYC_1;
      3'h2:    period = adc_ctrl_pkg::DIV_CYC_2;
      3'h3:    period = adc_ctrl_pkg::DIV_CYC_3;
      3'h4:    period = adc_ctrl_pkg::DIV_CYC_4;
      3'h5:    period = adc_ctrl_pkg::DIV_CYC_5;
      3'h6:    period = adc_ctrl_pkg::DIV_CYC_6;
      default: period = adc_ctrl_pkg::DIV_CYC_7;
    endcase
  end

  assign o_tick = i_run && (cnt_q == period - 6'h01);

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= 6'h00;
    end else if (!i_run || o_tick) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  // High during the first half of each period
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_clk_level_q <= 1'b0;
    end else begin
      o_clk_level_q <= i_run && (o_tick || ((cnt_q + 6'h01) < (period >> 1)));
    end
  end

endmodule
`default_nettype wire

/* design/sticky_bits.sv */
// Sticky event bits, cleared by writing one, set wins over clear
`timescale 1ns/1ns
`default_nettype none
module sticky_bits #(
  parameter int W = 2
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_set,
  input  wire logic         i_clr_wr,
  input  wire logic [W-1:0] i_clr,
  output logic      [W-1:0] o_bits_q
);

  logic [W-1:0] clr_mask;

  assign clr_mask = i_clr_wr ? i_clr : '0;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bits_q <= '0;
    end else begin
      o_bits_q <= (o_bits_q & ~clr_mask) | i_set;
    end
  end

endmodule
`default_nettype wire

/* design/adc_timing_compare_control.sv */
// Converter control: timing, pin function, result/threshold, compare mode
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module adc_timing_compare_control (
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Analog core
  input  wire logic [9:0]  i_core_result,
  output logic             o_converter_on,
  output logic      [2:0]  o_input_sel_mux,
  output logic             o_ref_source_sel,
  output logic      [7:0]  o_pin_function_bits,
  output logic             o_sample,
  output logic             o_convert,
  output logic             o_conv_clk,
  // Interrupt
  output logic             o_irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic       converter_on_q;
  logic       conv_done_flag_q;
  logic       compare_enable_q;
  logic       ref_source_sel_q;
  logic [2:0] input_sel_mux_q;
  logic       busy_q;
  logic [2:0] conv_clk_div_q;
  logic [3:0] sample_length_sel_q;
  logic [7:0] pin_function_bits_q;
  logic [9:0] result_bits_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_status;

  adc_ctrl_pkg::conv_state_e state_q;
  logic [4:0] period_cnt_q;
  logic [4:0] sample_len;
  logic       tick;
  logic       clk_level;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic       setup;
  logic       access;
  logic       wr;
  logic [9:0] idx;
  logic [7:0] wbyte;
  logic       mapped;

  assign setup  = i_psel && !i_penable;
  assign access = i_psel && i_penable && o_pready;
  assign wr     = access && i_pwrite && i_pstrb[0] && !o_pslverr;
  assign idx    = i_paddr[11:2];
  assign wbyte  = i_pwdata[7:0];

  always_comb begin
    case (idx)
      adc_ctrl_pkg::IDX_CONTROL,
      adc_ctrl_pkg::IDX_TIMING,
      adc_ctrl_pkg::IDX_PIN_FUNC,
      adc_ctrl_pkg::IDX_RESULT_LOW,
      adc_ctrl_pkg::IDX_RESULT_HIGH,
      adc_ctrl_pkg::IDX_IRQ_STATUS,
      adc_ctrl_pkg::IDX_IRQ_MASK: mapped = 1'b1;
      default:                    mapped = 1'b0;
    endcase
  end

  logic wr_ctl;
  logic wr_tim;
  logic wr_pin;
  logic wr_lo;
  logic wr_hi;
  logic wr_sts;
  logic wr_msk;

  assign wr_ctl = wr && (idx == adc_ctrl_pkg::IDX_CONTROL);
  assign wr_tim = wr && (idx == adc_ctrl_pkg::IDX_TIMING);
  assign wr_pin = wr && (idx == adc_ctrl_pkg::IDX_PIN_FUNC);
  assign wr_lo  = wr && (idx == adc_ctrl_pkg::IDX_RESULT_LOW);
  assign wr_hi  = wr && (idx == adc_ctrl_pkg::IDX_RESULT_HIGH);
  assign wr_sts = wr && (idx == adc_ctrl_pkg::IDX_IRQ_STATUS);
  assign wr_msk = wr && (idx == adc_ctrl_pkg::IDX_IRQ_MASK);

  // Zero wait: answer in the first access cycle
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup && !mapped;
    end
  end

  logic [7:0] rbyte;

  always_comb begin
    case (idx)
      adc_ctrl_pkg::IDX_CONTROL:     rbyte = {converter_on_q, conv_done_flag_q,
                                              compare_enable_q, ref_source_sel_q,
                                              input_sel_mux_q, busy_q};
      adc_ctrl_pkg::IDX_TIMING:      rbyte = {conv_clk_div_q, 1'b0, sample_length_sel_q};
      adc_ctrl_pkg::IDX_PIN_FUNC:    rbyte = pin_function_bits_q;
      adc_ctrl_pkg::IDX_RESULT_LOW:  rbyte = {6'h00, result_bits_q[1:0]};
      adc_ctrl_pkg::IDX_RESULT_HIGH: rbyte = result_bits_q[9:2];
      adc_ctrl_pkg::IDX_IRQ_STATUS:  rbyte = {6'h00, irq_status};
      adc_ctrl_pkg::IDX_IRQ_MASK:    rbyte = {6'h00, irq_mask_q};
      default:                       rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup) begin
      o_prdata <= {24'h000000, rbyte};
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  logic running;
  logic last_sample;
  logic last_convert;
  logic complete;
  logic abort;
  logic cmp_hit;

  always_comb begin
    if ({1'b0, sample_length_sel_q} + 5'h01 < adc_ctrl_pkg::SAMPLE_MIN) begin
      sample_len = adc_ctrl_pkg::SAMPLE_MIN;
    end else if ({1'b0, sample_length_sel_q} + 5'h01 > adc_ctrl_pkg::SAMPLE_MAX) begin
      sample_len = adc_ctrl_pkg::SAMPLE_MAX;
    end else begin
      sample_len = {1'b0, sample_length_sel_q} + 5'h01;
    end
  end

  assign running      = (state_q != adc_ctrl_pkg::ST_IDLE);
  assign last_sample  = (state_q == adc_ctrl_pkg::ST_SAMPLE) && tick &&
                        (period_cnt_q == sample_len - 5'h01);
  assign last_convert = (state_q == adc_ctrl_pkg::ST_CONVERT) && tick &&
                        (period_cnt_q == adc_ctrl_pkg::CONVERT_LEN - 5'h01);
  // Stop on busy cleared or converter switched off
  assign abort        = running && (!busy_q || !converter_on_q);
  assign complete     = last_convert && !abort;
  assign cmp_hit      = complete && compare_enable_q &&
                        (i_core_result > result_bits_q);

  conv_clk_divider u_div (
    .i_sys_clk     (i_sys_clk),
    .i_nrst        (i_nrst),
    .i_run         (running && !abort),
    .i_div_code    (conv_clk_div_q),
    .o_tick        (tick),
    .o_clk_level_q (clk_level)
  );

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q      <= adc_ctrl_pkg::ST_IDLE;
      period_cnt_q <= 5'h00;
    end else begin
      case (state_q)
        adc_ctrl_pkg::ST_IDLE: begin
          period_cnt_q <= 5'h00;
          if (busy_q && converter_on_q) begin
            state_q <= adc_ctrl_pkg::ST_SAMPLE;
          end
        end
        adc_ctrl_pkg::ST_SAMPLE: begin
          if (abort) begin
            state_q      <= adc_ctrl_pkg::ST_IDLE;
            period_cnt_q <= 5'h00;
          end else if (last_sample) begin
            state_q      <= adc_ctrl_pkg::ST_CONVERT;
            period_cnt_q <= 5'h00;
          end else if (tick) begin
            period_cnt_q <= period_cnt_q + 5'h01;
          end
        end
        adc_ctrl_pkg::ST_CONVERT: begin
          if (abort) begin
            state_q      <= adc_ctrl_pkg::ST_IDLE;
            period_cnt_q <= 5'h00;
          end else if (complete) begin
            // Compare mode loops straight into the next sample
            state_q      <= compare_enable_q ? adc_ctrl_pkg::ST_SAMPLE
                                             : adc_ctrl_pkg::ST_IDLE;
            period_cnt_q <= 5'h00;
          end else if (tick) begin
            period_cnt_q <= period_cnt_q + 5'h01;
          end
        end
        default: begin
          state_q      <= adc_ctrl_pkg::ST_IDLE;
          period_cnt_q <= 5'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      converter_on_q   <= 1'b0;
      compare_enable_q <= 1'b0;
      ref_source_sel_q <= 1'b0;
      input_sel_mux_q  <= 3'h0;
    end else if (wr_ctl) begin
      converter_on_q   <= wbyte[adc_ctrl_pkg::CTL_ON_BIT];
      compare_enable_q <= wbyte[adc_ctrl_pkg::CTL_CMP_BIT];
      ref_source_sel_q <= wbyte[adc_ctrl_pkg::CTL_REF_BIT];
      input_sel_mux_q  <= wbyte[adc_ctrl_pkg::CTL_SEL_LSB +: 3];
    end
  end

  // Busy: software write wins over hardware clear
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_q <= 1'b0;
    end else if (wr_ctl) begin
      busy_q <= wbyte[adc_ctrl_pkg::CTL_GO_BIT] && wbyte[adc_ctrl_pkg::CTL_ON_BIT];
    end else if (!converter_on_q) begin
      busy_q <= 1'b0;
    end else if (complete && !compare_enable_q) begin
      busy_q <= 1'b0;
    end
  end

  // Done flag: only hardware sets, a written zero clears, set wins
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      conv_done_flag_q <= 1'b0;
    end else if ((complete && !compare_enable_q) || cmp_hit) begin
      conv_done_flag_q <= 1'b1;
    end else if (wr_ctl && !wbyte[adc_ctrl_pkg::CTL_DONE_BIT]) begin
      conv_done_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Timing, pin function and result registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      conv_clk_div_q      <= adc_ctrl_pkg::RST_BYTE[2:0];
      sample_length_sel_q <= adc_ctrl_pkg::RST_BYTE[3:0];
    end else if (wr_tim) begin
      conv_clk_div_q      <= wbyte[adc_ctrl_pkg::TIM_DIV_LSB +: 3];
      sample_length_sel_q <= wbyte[adc_ctrl_pkg::TIM_SAMPLE_LSB +: 4];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_function_bits_q <= adc_ctrl_pkg::RST_BYTE;
    end else if (wr_pin) begin
      pin_function_bits_q <= wbyte;
    end
  end

  // Single conversion result overrides a same-cycle software write
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      result_bits_q <= adc_ctrl_pkg::RST_RESULT;
    end else if (complete && !compare_enable_q) begin
      result_bits_q <= i_core_result;
    end else begin
      if (wr_hi) begin
        result_bits_q[9:2] <= wbyte;
      end
      if (wr_lo) begin
        result_bits_q[1:0] <= wbyte[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  logic [1:0] irq_set;

  assign irq_set[adc_ctrl_pkg::IRQ_DONE_BIT] = complete && !compare_enable_q;
  assign irq_set[adc_ctrl_pkg::IRQ_CMP_BIT]  = cmp_hit;

  sticky_bits #(
    .W (adc_ctrl_pkg::IRQ_WIDTH)
  ) u_irq_status (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_set     (irq_set),
    .i_clr_wr  (wr_sts),
    .i_clr     (wbyte[1:0]),
    .o_bits_q  (irq_status)
  );

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_mask_q <= adc_ctrl_pkg::RST_IRQ;
    end else if (wr_msk) begin
      irq_mask_q <= wbyte[1:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the analog core
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_converter_on      <= 1'b0;
      o_input_sel_mux     <= 3'h0;
      o_ref_source_sel    <= 1'b0;
      o_pin_function_bits <= adc_ctrl_pkg::RST_BYTE;
      o_sample            <= 1'b0;
      o_convert           <= 1'b0;
    end else begin
      o_converter_on      <= converter_on_q;
      o_input_sel_mux     <= input_sel_mux_q;
      o_ref_source_sel    <= ref_source_sel_q;
      o_pin_function_bits <= pin_function_bits_q;
      o_sample            <= (state_q == adc_ctrl_pkg::ST_SAMPLE) && !abort;
      o_convert           <= (state_q == adc_ctrl_pkg::ST_CONVERT) && !abort;
    end
  end

  assign o_conv_clk = clk_level;

endmodule
`default_nettype wire

/* test/analog_core_model.sv */
// Behavioural analog core returning a channel-dependent code
`timescale 1ns/1ns
`default_nettype none
module analog_core_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_convert,
  input  wire logic [2:0] i_sel,
  output logic      [9:0] o_result
);
  logic [9:0] churn_q = 10'h000;
  always @(posedge i_sys_clk) begin
    churn_q <= churn_q + 10'h1F3;
  end
  // Valid code only while converting, churning otherwise
  assign o_result = i_convert ? {i_sel, 7'h35} : churn_q;
endmodule
`default_nettype wire

/* test/adc_ctrl_assertions.sv */
// Port-level checks for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_ctrl_assertions (
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0]  i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_converter_on,
  input wire logic        o_sample,
  input wire logic        o_convert,
  input wire logic        o_conv_clk
);
  logic [7:0] tim_q;
  logic [9:0] smp_q;
  logic [9:0] cnv_q;
  logic [5:0] hi_q;
  logic [5:0] lo_q;
  logic [5:0] div;
  logic [4:0] slen;
  logic [9:0] smp_len;
  logic [9:0] cnv_len;
  logic       map;
  // --------------------------------------------------------------
  // Timing shadow and run counters
  // --------------------------------------------------------------
  always_comb begin
    case (tim_q[7:5])
      3'h0: div = 6'h02;
      3'h1: div = 6'h04;
      3'h2: div = 6'h06;
      3'h3: div = 6'h08;
      3'h4: div = 6'h0C;
      3'h5: div = 6'h10;
      3'h6: div = 6'h18;
      default: div = 6'h20;
    endcase
  end
  assign slen = (tim_q[3:0] == 4'h0) ? 5'h02 :
                (tim_q[3:0] == 4'hF) ? 5'h0F : 5'(tim_q[3:0]) + 5'h01;
  assign smp_len = 10'(slen) * 10'(div);
  assign cnv_len = 10'h00C * 10'(div);
  assign map = i_paddr[11:2] >= adc_ctrl_pkg::IDX_CONTROL &&
               i_paddr[11:2] <= adc_ctrl_pkg::IDX_IRQ_MASK;
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tim_q <= 8'h00;
    end else if (i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0] &&
                 i_paddr[11:2] == adc_ctrl_pkg::IDX_TIMING) begin
      tim_q <= i_pwdata[7:0];
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      smp_q <= 10'h000;
      cnv_q <= 10'h000;
      hi_q  <= 6'h00;
      lo_q  <= 6'h00;
    end else begin
      smp_q <= o_sample ? smp_q + 10'h001 : 10'h000;
      cnv_q <= o_convert ? cnv_q + 10'h001 : 10'h000;
      hi_q  <= o_conv_clk ? hi_q + 6'h01 : 6'h00;
      lo_q  <= (!o_conv_clk && (o_sample || o_convert)) ? lo_q + 6'h01 : 6'h00;
    end
  end
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);
  AST_RDY_SETUP: assert property (i_psel && !i_penable |=> o_pready)
    else $error("ready missing after setup");
  AST_RDY_PULSE: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  AST_ERR_MAP: assert property (i_psel && !i_penable && map |=> !o_pslverr)
    else $error("error on mapped register");
  AST_ERR_UNMAP: assert property (i_psel && !i_penable && !map |=> o_pslverr)
    else $error("no error on unmapped address");
  AST_RD_UPPER: assert property (o_pready |-> o_prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  AST_SMP_MAX: assert property (o_sample |-> smp_q < smp_len)
    else $error("sample phase too long");
  AST_SMP_EXACT: assert property ($rose(o_convert) |-> smp_q == smp_len)
    else $error("sample phase length wrong");
  AST_CNV_MAX: assert property (o_convert |-> cnv_q < cnv_len)
    else $error("conversion phase too long");
  AST_ON_GATES: assert property (!o_converter_on |=> !o_sample && !o_convert)
    else $error("activity while converter off");
  AST_CLK_HALF: assert property (o_conv_clk |-> hi_q < 6'(div[5:1]))
    else $error("conversion clock high too long");
  AST_CLK_LOW: assert property (!o_conv_clk && (o_sample || o_convert) |-> lo_q < div)
    else $error("conversion clock stuck low");
endmodule
bind adc_timing_compare_control adc_ctrl_assertions u_adc_ctrl_assertions (
  .i_sys_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .o_converter_on, .o_sample,
  .o_convert, .o_conv_clk
);
`default_nettype wire

/* test/adc_timing_compare_control_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_timing_compare_control_tb;
  typedef struct packed {logic [2:0] dv; logic [3:0] ts; logic [9:0] cyc;} row_s;
  localparam logic [11:0] A_CTL = {adc_ctrl_pkg::IDX_CONTROL, 2'b00};
  localparam logic [11:0] A_TIM = {adc_ctrl_pkg::IDX_TIMING, 2'b00};
  localparam logic [11:0] A_PIN = {adc_ctrl_pkg::IDX_PIN_FUNC, 2'b00};
  localparam logic [11:0] A_LO  = {adc_ctrl_pkg::IDX_RESULT_LOW, 2'b00};
  localparam logic [11:0] A_HI  = {adc_ctrl_pkg::IDX_RESULT_HIGH, 2'b00};
  localparam logic [11:0] A_STS = {adc_ctrl_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] A_MSK = {adc_ctrl_pkg::IDX_IRQ_MASK, 2'b00};
  row_s rows [8] = '{'{3'h0, 4'h0, 10'h01C}, '{3'h1, 4'h3, 10'h040},
                     '{3'h2, 4'h2, 10'h05A}, '{3'h3, 4'h4, 10'h088},
                     '{3'h4, 4'hF, 10'h144}, '{3'h5, 4'hE, 10'h1B0},
                     '{3'h6, 4'h1, 10'h150}, '{3'h7, 4'h7, 10'h280}};
  logic        i_sys_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h00000000;
  logic [3:0]  i_pstrb = 4'hF;
  logic [9:0]  i_core_result;
  logic [31:0] o_prdata;
  logic        o_pready, o_pslverr, o_converter_on, o_ref_source_sel;
  logic [2:0]  o_input_sel_mux;
  logic [7:0]  o_pin_function_bits;
  logic        o_sample, o_convert, o_conv_clk, o_irq;
  int          n_mismatch = 0;
  int          n_checks = 0;
  logic [31:0] d, n;
  logic        e, pc;
  logic [7:0]  ctl;
  int          m;
  row_s        r;
  always #25 i_sys_clk = ~i_sys_clk;
  adc_timing_compare_control u_adc_timing_compare_control (
    .i_sys_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_core_result, .o_converter_on,
    .o_input_sel_mux, .o_ref_source_sel, .o_pin_function_bits, .o_sample,
    .o_convert, .o_conv_clk, .o_irq);
  analog_core_model u_analog_core_model (
    .i_sys_clk, .i_convert(o_convert), .i_sel(o_input_sel_mux), .o_result(i_core_result));
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd,
                     output logic [31:0] rv, output logic er);
    @(posedge i_sys_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= {24'h000000, wd};
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    for (int k = 0; k <= 16; k++) begin
      @(posedge i_sys_clk);
      if (o_pready === 1'b1) break;
      if (k == 16) begin
        n_mismatch++;
        results();
      end
    end
    rv = o_prdata;
    er = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] wd);
    logic [31:0] x;
    logic        er;
    apb(1'b1, a, wd, x, er);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] ex);
    logic [31:0] x;
    logic        er;
    apb(1'b0, a, 8'h00, x, er);
    chk(x, {24'h000000, ex});
  endtask
  task automatic run(output logic [31:0] cnt);
    cnt = 32'h0;
    for (int k = 0; k < 2000; k++) begin
      @(posedge i_sys_clk);
      if (o_sample || o_convert) cnt = cnt + 32'h1;
      else if (cnt != 32'h0) return;
    end
    n_mismatch++;
    results();
  endtask
  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      ctl = {3'b100, r.dv[1], r.dv, 1'b1};
      wr(A_MSK, {7'h00, r.dv[0]});
      wr(A_TIM, {r.dv, 1'b0, r.ts});
      wr(A_CTL, ctl);
      run(n);
      chk(n, 32'(r.cyc));
      chk(32'(o_input_sel_mux), 32'(r.dv));
      chk(32'(o_ref_source_sel), 32'(r.dv[1]));
      @(posedge i_sys_clk);
      chk(32'(o_irq), 32'(r.dv[0]));
      rd(A_CTL, ctl ^ 8'h41);
      rd(A_HI, {r.dv, 5'h0D});
      apb(1'b0, A_LO, 8'h00, d, e);
      chk(32'(d[1:0]), 32'h1);
      rd(A_STS, 8'h01);
      wr(A_STS, 8'h01);
      wr(A_CTL, ctl & 8'hBE);
      rd(A_CTL, ctl & 8'hBE);
      rd(A_STS, 8'h00);
    end
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    for (logic [11:0] a = A_CTL; a <= A_MSK; a += 12'h004) rd(a, 8'h00);
    chk(32'({o_converter_on, o_ref_source_sel, o_input_sel_mux, o_irq}), 32'h0);
    wr(A_TIM, 8'hFF);
    rd(A_TIM, 8'hEF);
    wr(A_PIN, 8'hA5);
    rd(A_PIN, 8'hA5);
    chk(32'(o_pin_function_bits), 32'hA5);
    wr(A_CTL, 8'h40);
    rd(A_CTL, 8'h00);
    apb(1'b1, 12'h300, 8'hFF, d, e);
    chk(32'(e), 32'h1);
    apb(1'b0, 12'h300, 8'h00, d, e);
    chk(d, 32'h0);
    wr(A_CTL, 8'h01);
    rd(A_CTL, 8'h00);
    chk(32'(o_sample), 32'h0);
    wr(A_TIM, 8'hEF);
    wr(A_HI, 8'h3C);
    wr(A_CTL, 8'h81);
    repeat (600) @(posedge i_sys_clk);
    chk(32'(o_convert), 32'h1);
    wr(A_CTL, 8'h80);
    repeat (2) @(posedge i_sys_clk);
    chk(32'(o_sample || o_convert), 32'h0);
    rd(A_CTL, 8'h80);
    rd(A_HI, 8'h3C);
    rd(A_STS, 8'h00);
    wr(A_TIM, 8'h00);
    for (int j = 0; j < 2; j++) begin
      wr(A_CTL, 8'h0A);
      wr(A_HI, 8'hAD);
      wr(A_LO, {7'h00, j == 0});
      wr(A_CTL, 8'h2A);
      wr(A_CTL, 8'hAA);
      wr(A_CTL, 8'hAB);
      m = 0;
      pc = 1'b0;
      for (int k = 0; k < 120; k++) begin
        @(posedge i_sys_clk);
        if (o_convert && !pc) m++;
        pc = o_convert;
      end
      chk(32'(m >= 3), 32'h1);
      rd(A_CTL, (j == 1) ? 8'hEB : 8'hAB);
      rd(A_HI, 8'hAD);
      rd(A_STS, (j == 1) ? 8'h02 : 8'h00);
      wr(A_CTL, 8'hAA);
      repeat (2) @(posedge i_sys_clk);
      chk(32'(o_sample || o_convert), 32'h0);
      wr(A_STS, 8'h03);
    end
    results();
  end
endmodule
`default_nettype wire
